// ---- tmr_ctrl_pkg.sv ----
// Package with register map, field positions and modes of the timer control block
package tmr_ctrl_pkg;

  // Register map, byte offsets on the plain register port
  localparam logic [7:0] ADDR_FAULT_WAVE_CTRL = 8'h26;
  localparam logic [7:0] ADDR_CHAN_D_OUT_CTRL = 8'h27;
  localparam logic [7:0] ADDR_CLK_DT_CTRL     = 8'h2f;

  // Reset values
  localparam logic [7:0] RST_FAULT_WAVE_CTRL = 8'h00;
  localparam logic [7:0] RST_CHAN_D_OUT_CTRL = 8'h00;
  localparam logic [7:0] RST_CLK_DT_CTRL     = 8'h00;

  // Clock and dead-time control fields
  localparam int POS_PWM_INVERT   = 7;
  localparam int POS_PRESCALER_RST = 6;
  localparam int POS_DT_SEL_LO    = 4;
  localparam int POS_CLK_SEL_LO   = 0;

  // Channel D output control fields
  localparam int POS_SHADOW_A_LO  = 6;
  localparam int POS_SHADOW_B_LO  = 4;
  localparam int POS_MODE_D_LO    = 2;
  localparam int POS_FORCE_D      = 1;
  localparam int POS_PWM_D_EN     = 0;

  // Fault and waveform mode fields
  localparam int POS_FAULT_IRQ_EN = 7;
  localparam int POS_FAULT_CFG_LO = 3;
  localparam int POS_FAULT_FLAG   = 2;
  localparam int POS_WAVE_SEL_LO  = 0;

  // Prescaler depth: largest division is 2 to the power 14
  localparam int PRESCALE_BITS = 14;
  localparam int DT_DIV_BITS   = 3;

  // Compare-output action codes
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  // Waveform generation modes while PWM is enabled
  typedef enum logic [1:0] {
    WAVE_FAST,
    WAVE_PHASE_FREQ,
    WAVE_SIX_SINGLE,
    WAVE_SIX_DUAL
  } wave_mode_e;

  // True and complementary pair of a dead-time generator output
  typedef struct packed {
    logic true_out;
    logic comp_out;
  } deadtime_pair_s;

  // Counter core events seen by channel D
  typedef struct packed {
    logic match_d;
    logic at_zero;
    logic count_down;
  } count_evt_s;

endpackage

// ---- tmr_ctrl.sv ----
// Timer clock select, prescalers, inversion, fault flag and channel D output control
`timescale 1ns/10ps

// Contract
// - Inversion bit inverts both dead-time outputs
// - Prescaler reset bit restarts prescaler, not counter
// - Prescaler reset self-clears, reads zero, zero ignored
// - Dead-time divider selects one, two, four, eight
// - Dead-time divider runs from base timer clock, not clock select
// - Clock code n divides by two^(n-1)
// - Clock code zero stops the timer
// - Shadow copies of channel A, B modes
// - Nonzero mode connects pin; complement only PWM 01
// - Mode decode depends on PWM enable, wave select
// - Non-PWM: toggle, clear, set on match
// - Fast PWM: clear on match, set at zero
// - Phase-correct PWM: clear up, set down
// - Force works only in non-PWM mode
// - Force applies match action without interrupt
// - Force uses mode written same cycle
// - Force bit always reads zero
// - PWM enable puts channel D in PWM
// - Wave select picks fast, phase, six-output modes
// - Fault flag clears by vector or write-one
module tmr_ctrl
  import tmr_ctrl_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input  wire logic              CORE_CLK_I,
  input  wire logic              RST_B_I,
  input  wire logic [ADDR_W-1:0] ADDR_I,
  input  wire logic [7:0]        WDATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  output logic [7:0]             RDATA_O,
  input  wire logic              ASYNC_MODE_I,
  input  wire logic              FAST_TICK_I,
  output logic                   TIMER_TICK_O,
  output logic                   DT_TICK_O,
  input  wire deadtime_pair_s    DT_PAIR_I,
  output deadtime_pair_s         DT_PAIR_O,
  input  wire count_evt_s        COUNT_EVT_I,
  output logic                   WAVEFORM_D_O,
  output logic                   PIN_D_CONNECT_O,
  output logic                   PIN_D_N_CONNECT_O,
  output logic                   PWM_D_ENABLE_O,
  output logic [1:0]             WAVE_MODE_O,
  output logic [1:0]             SHADOW_MODE_A_O,
  output logic [1:0]             SHADOW_MODE_B_O,
  input  wire logic              FAULT_EVENT_I,
  input  wire logic              FAULT_VECTOR_ACK_I,
  output logic                   FAULT_IRQ_O,
  output logic [3:0]             FAULT_CFG_O
);

  // Control registers
  logic [7:0]               clk_dt_q;
  logic [7:0]               clk_dt_d;
  logic [7:0]               chan_d_q;
  logic [7:0]               chan_d_d;
  logic [7:0]               fault_wave_q;
  logic [7:0]               fault_wave_d;
  logic                     psr_pend_q;
  logic                     psr_pend_d;
  logic                     flag_clr_pend_q;
  logic                     flag_clr_pend_d;
  logic [PRESCALE_BITS-1:0] pre_cnt_q;
  logic [PRESCALE_BITS-1:0] pre_cnt_d;
  logic [DT_DIV_BITS-1:0]   dt_cnt_q;
  logic [DT_DIV_BITS-1:0]   dt_cnt_d;
  logic                     wave_d_q;
  logic                     wave_d_d;
  logic [7:0]               rdata_q;
  logic [7:0]               rdata_d;
  logic                     timer_tick_q;
  logic                     dt_tick_q;
  deadtime_pair_s           dt_pair_q;
  logic                     pin_con_q;
  logic                     pin_n_con_q;
  logic                     irq_q;

  // Address decode
  wire sel_fault = (ADDR_I == ADDR_W'(ADDR_FAULT_WAVE_CTRL));
  wire sel_chan  = (ADDR_I == ADDR_W'(ADDR_CHAN_D_OUT_CTRL));
  wire sel_clk   = (ADDR_I == ADDR_W'(ADDR_CLK_DT_CTRL));
  wire wr_fault  = WR_I & sel_fault;
  wire wr_chan   = WR_I & sel_chan;
  wire wr_clk    = WR_I & sel_clk;

  // Field views of the stored registers
  wire       pwm_invert = clk_dt_q[POS_PWM_INVERT];
  wire [1:0] dt_sel     = clk_dt_q[POS_DT_SEL_LO +: 2];
  wire [3:0] clk_sel    = clk_dt_q[POS_CLK_SEL_LO +: 4];
  wire [1:0] mode_d     = chan_d_q[POS_MODE_D_LO +: 2];
  wire       pwm_d_en   = chan_d_q[POS_PWM_D_EN];
  wire [1:0] wave_sel   = fault_wave_q[POS_WAVE_SEL_LO +: 2];
  wire       fault_flag = fault_wave_q[POS_FAULT_FLAG];
  wire       fault_ie   = fault_wave_q[POS_FAULT_IRQ_EN];

  // Base timer clock: every core cycle when synchronous, else each fast tick
  wire base_tick = ASYNC_MODE_I ? FAST_TICK_I : 1'b1;

  // Clock and dead-time register; prescaler reset bit is never stored
  assign clk_dt_d = wr_clk ? (WDATA_I & ~(8'h01 << POS_PRESCALER_RST)) : clk_dt_q;

  // A written one raises a pending request that the next base tick consumes
  assign psr_pend_d = (wr_clk & WDATA_I[POS_PRESCALER_RST]) |
                      (psr_pend_q & ~base_tick);

  // Prescaler counts base ticks; restarts from zero on a reset request
  assign pre_cnt_d = !base_tick ? pre_cnt_q :
                     psr_pend_q ? '0 :
                     (clk_sel == 4'h0) ? pre_cnt_q :
                     pre_cnt_q + PRESCALE_BITS'(1);

  // Divided tick: low n-1 bits all ones means a 2^(n-1) period has passed
  wire [PRESCALE_BITS:0]   pre_mask_w = (PRESCALE_BITS+1)'(1) << (clk_sel - 4'h1);
  wire [PRESCALE_BITS-1:0] pre_mask   = pre_mask_w[PRESCALE_BITS-1:0] - PRESCALE_BITS'(1);
  wire timer_tick = base_tick & ~psr_pend_q & (clk_sel != 4'h0) &
                    ((pre_cnt_q & pre_mask) == pre_mask);

  // Dead-time divider runs from the base timer clock, so it stays with FAST_PERIPH_CLOCK or CK
  wire [DT_DIV_BITS-1:0] dt_mask = DT_DIV_BITS'((4'h1 << dt_sel) - 4'h1);
  assign dt_cnt_d = base_tick ? dt_cnt_q + DT_DIV_BITS'(1) : dt_cnt_q;
  wire dt_tick = base_tick & ((dt_cnt_q & dt_mask) == dt_mask);

  // Channel D register; force bit only acts as a strobe and is never stored
  assign chan_d_d = wr_chan ? (WDATA_I & ~(8'h01 << POS_FORCE_D)) : chan_d_q;

  // Force takes the mode from the write data, so a same-cycle mode change counts
  wire [1:0] force_mode = WDATA_I[POS_MODE_D_LO +: 2];
  wire       force_hit  = wr_chan & WDATA_I[POS_FORCE_D] &
                          ~WDATA_I[POS_PWM_D_EN] & ~pwm_d_en;

  // Waveform action decode for channel D
  logic wave_next;
  always_comb
  begin
    wave_next = wave_d_q;
    if (force_hit)
    begin
      // Forced match: same action as a real match, no interrupt path here
      case (force_mode)
        COM_TOGGLE: wave_next = ~wave_d_q;
        COM_CLEAR:  wave_next = 1'b0;
        COM_SET:    wave_next = 1'b1;
        default:    wave_next = wave_d_q;
      endcase
    end
    else if (!pwm_d_en)
    begin
      if (COUNT_EVT_I.match_d)
      begin
        case (mode_d)
          COM_TOGGLE: wave_next = ~wave_d_q;
          COM_CLEAR:  wave_next = 1'b0;
          COM_SET:    wave_next = 1'b1;
          default:    wave_next = wave_d_q;
        endcase
      end
    end
    else if (mode_d != COM_OFF)
    begin
      case (wave_mode_e'(wave_sel))
        WAVE_FAST, WAVE_SIX_SINGLE:
        begin
          // Single slope: match and bottom drive opposite levels
          if (COUNT_EVT_I.match_d)
            wave_next = (mode_d == COM_SET);
          else if (COUNT_EVT_I.at_zero)
            wave_next = (mode_d != COM_SET);
        end
        default:
        begin
          // Dual slope: direction of the count picks the level on match
          if (COUNT_EVT_I.match_d)
            wave_next = (mode_d == COM_SET) ^ COUNT_EVT_I.count_down;
        end
      endcase
    end
  end
  assign wave_d_d = wave_next;

  // Pin connection follows the mode; complement only in PWM with toggle code
  wire pin_con   = (mode_d != COM_OFF);
  wire pin_n_con = pwm_d_en & (mode_d == COM_TOGGLE);

  // Fault register: flag set by event wins over either clear
  wire flag_wr1 = wr_fault & WDATA_I[POS_FAULT_FLAG];
  assign flag_clr_pend_d = flag_wr1;
  wire flag_next = FAULT_EVENT_I |
                   (fault_flag & ~FAULT_VECTOR_ACK_I & ~flag_clr_pend_q);
  logic [7:0] fault_wr_val;
  assign fault_wr_val = wr_fault ? WDATA_I : fault_wave_q;
  assign fault_wave_d = (fault_wr_val & ~(8'h01 << POS_FAULT_FLAG)) |
                        ({7'h00, flag_next} << POS_FAULT_FLAG);

  // Read mux; unmapped addresses read zero
  assign rdata_d = !RD_I     ? 8'h00 :
                   sel_clk   ? clk_dt_q :
                   sel_chan  ? chan_d_q :
                   sel_fault ? fault_wave_q :
                   8'h00;

  // Register file and control state; all clear to zero at reset
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      clk_dt_q        <= RST_CLK_DT_CTRL;
      chan_d_q        <= RST_CHAN_D_OUT_CTRL;
      fault_wave_q    <= RST_FAULT_WAVE_CTRL;
      psr_pend_q      <= 1'b0;
      flag_clr_pend_q <= 1'b0;
    end
    else
    begin
      clk_dt_q        <= clk_dt_d;
      chan_d_q        <= chan_d_d;
      fault_wave_q    <= fault_wave_d;
      psr_pend_q      <= psr_pend_d;
      flag_clr_pend_q <= flag_clr_pend_d;
    end
  end

  // Counters of the two prescalers
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      pre_cnt_q <= '0;
      dt_cnt_q  <= '0;
    end
    else
    begin
      pre_cnt_q <= pre_cnt_d;
      dt_cnt_q  <= dt_cnt_d;
    end
  end

  // Channel D waveform state
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      wave_d_q <= 1'b0;
    else
      wave_d_q <= wave_d_d;
  end

  // Registered outputs; adds one cycle of latency but keeps pins glitch free
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      rdata_q      <= 8'h00;
      timer_tick_q <= 1'b0;
      dt_tick_q    <= 1'b0;
      dt_pair_q    <= '0;
      pin_con_q    <= 1'b0;
      pin_n_con_q  <= 1'b0;
      irq_q        <= 1'b0;
    end
    else
    begin
      rdata_q            <= rdata_d;
      timer_tick_q       <= timer_tick;
      dt_tick_q          <= dt_tick;
      dt_pair_q.true_out <= DT_PAIR_I.true_out ^ pwm_invert;
      dt_pair_q.comp_out <= DT_PAIR_I.comp_out ^ pwm_invert;
      pin_con_q          <= pin_con;
      pin_n_con_q        <= pin_n_con;
      irq_q              <= fault_flag & fault_ie;
    end
  end

  // Output wiring straight from flip-flops
  assign RDATA_O           = rdata_q;
  assign TIMER_TICK_O      = timer_tick_q;
  assign DT_TICK_O         = dt_tick_q;
  assign DT_PAIR_O         = dt_pair_q;
  assign WAVEFORM_D_O      = wave_d_q;
  assign PIN_D_CONNECT_O   = pin_con_q;
  assign PIN_D_N_CONNECT_O = pin_n_con_q;
  assign PWM_D_ENABLE_O    = chan_d_q[POS_PWM_D_EN];
  assign WAVE_MODE_O       = fault_wave_q[POS_WAVE_SEL_LO +: 2];
  assign SHADOW_MODE_A_O   = chan_d_q[POS_SHADOW_A_LO +: 2];
  assign SHADOW_MODE_B_O   = chan_d_q[POS_SHADOW_B_LO +: 2];
  assign FAULT_IRQ_O       = irq_q;
  assign FAULT_CFG_O       = fault_wave_q[POS_FAULT_CFG_LO +: 4];

endmodule

// ---- tmr_ctrl_properties.sv ----
// Checker for register, channel D and fault behaviour at the timer control ports
`timescale 1ns/10ps
module tmr_ctrl_properties
  import tmr_ctrl_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input wire logic              CORE_CLK_I,
  input wire logic              RST_B_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [7:0]        WDATA_I,
  input wire logic              WR_I,
  input wire logic              RD_I,
  input wire logic [7:0]        RDATA_O,
  input wire deadtime_pair_s    DT_PAIR_I,
  input wire deadtime_pair_s    DT_PAIR_O,
  input wire count_evt_s        COUNT_EVT_I,
  input wire logic              WAVEFORM_D_O,
  input wire logic              PIN_D_CONNECT_O,
  input wire logic              PIN_D_N_CONNECT_O,
  input wire logic              PWM_D_ENABLE_O,
  input wire logic [1:0]        SHADOW_MODE_A_O,
  input wire logic [1:0]        SHADOW_MODE_B_O,
  input wire logic              FAULT_EVENT_I,
  input wire logic              FAULT_VECTOR_ACK_I,
  input wire logic              FAULT_IRQ_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  // Write decodes shared by several checks
  wire wr_clk  = WR_I && ADDR_I == ADDR_CLK_DT_CTRL;
  wire wr_chan = WR_I && ADDR_I == ADDR_CHAN_D_OUT_CTRL;
  wire no_evt  = !COUNT_EVT_I.match_d && !COUNT_EVT_I.at_zero;

  rst_bit_zero_a: assert property (RD_I && ADDR_I == ADDR_CLK_DT_CTRL |=> !RDATA_O[6])
    else $error("prescaler reset bit read back set");
  force_bit_zero_a: assert property (RD_I && ADDR_I == ADDR_CHAN_D_OUT_CTRL |=> !RDATA_O[1])
    else $error("force bit read back set");
  pwm_invert_a: assert property (wr_clk ##1 1 |=>
    DT_PAIR_O == ($past(DT_PAIR_I) ^ {2{$past(WDATA_I[7], 2)}}))
    else $error("dead-time pair inversion wrong");
  // Pin connects are registered from the stored mode, so they trail the write by two cycles
  pin_connect_a: assert property (wr_chan ##1 !wr_chan |=>
    PIN_D_CONNECT_O == ($past(WDATA_I[3:2], 2) != 2'h0)
    && PIN_D_N_CONNECT_O == ($past(WDATA_I[3:2], 2) == 2'h1 && $past(WDATA_I[0], 2)))
    else $error("pin connection wrong");
  shadow_copy_a: assert property (wr_chan |=> SHADOW_MODE_A_O == $past(WDATA_I[7:6])
    && SHADOW_MODE_B_O == $past(WDATA_I[5:4])) else $error("shadow mode wrong");
  pwm_enable_a: assert property (wr_chan |=> PWM_D_ENABLE_O == $past(WDATA_I[0]))
    else $error("pwm enable wrong");
  force_toggle_a: assert property (wr_chan && WDATA_I[3:0] == 4'h6 && !PWM_D_ENABLE_O
    |=> WAVEFORM_D_O != $past(WAVEFORM_D_O)) else $error("forced toggle missing");
  force_ignored_a: assert property (wr_chan && WDATA_I[1] && (WDATA_I[0] || PWM_D_ENABLE_O)
    && no_evt |=> $stable(WAVEFORM_D_O)) else $error("force acted in pwm");
  vector_clear_a: assert property (FAULT_VECTOR_ACK_I && !FAULT_EVENT_I ##1 1 |=> !FAULT_IRQ_O)
    else $error("fault flag kept after vector");
endmodule

bind tmr_ctrl tmr_ctrl_properties #(.ADDR_W(ADDR_W)) prop_u (.CORE_CLK_I(CORE_CLK_I),
  .RST_B_I(RST_B_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .DT_PAIR_I(DT_PAIR_I), .DT_PAIR_O(DT_PAIR_O), .COUNT_EVT_I(COUNT_EVT_I),
  .WAVEFORM_D_O(WAVEFORM_D_O), .PIN_D_CONNECT_O(PIN_D_CONNECT_O),
  .PIN_D_N_CONNECT_O(PIN_D_N_CONNECT_O), .PWM_D_ENABLE_O(PWM_D_ENABLE_O),
  .SHADOW_MODE_A_O(SHADOW_MODE_A_O), .SHADOW_MODE_B_O(SHADOW_MODE_B_O),
  .FAULT_EVENT_I(FAULT_EVENT_I), .FAULT_VECTOR_ACK_I(FAULT_VECTOR_ACK_I),
  .FAULT_IRQ_O(FAULT_IRQ_O));

// ---- power_stage_model.sv ----
// Switching stage model driven by the channel D pin
`timescale 1ns/10ps
module power_stage_model
(
  input  wire logic wave_i,
  input  wire logic connect_i,
  output logic      gate_o
);
  // A released pin is pulled low, so the gate never sees a stale level
  assign gate_o = connect_i & wave_i;
endmodule

// ---- testbench.sv ----
// Self-checking bench for the timer control block
`timescale 1ns/10ps
module testbench;
  import tmr_ctrl_pkg::*;
  logic           clk = 0, rst_b = 0, wr = 0, rd = 0, async_m = 0, fast = 0;
  logic           f_ev = 0, f_ack = 0, t_tick, d_tick, wave, pin, pin_n, irq, gate;
  logic [1:0]     wmode;
  logic [3:0]     fcfg;
  logic [7:0]     addr = 0, wdata = 0, rdata;
  deadtime_pair_s dt_i = 2'b10, dt_o;
  count_evt_s     evt = 0;
  int             num_errors = 0, n_checks = 0, nt, nd;

  // Core clock and a fast tick on every other cycle
  always #20 clk = ~clk;
  always @(posedge clk) fast <= ~fast;

  tmr_ctrl dut_u (.CORE_CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .ASYNC_MODE_I(async_m), .FAST_TICK_I(fast),
    .TIMER_TICK_O(t_tick), .DT_TICK_O(d_tick), .DT_PAIR_I(dt_i), .DT_PAIR_O(dt_o),
    .COUNT_EVT_I(evt), .WAVEFORM_D_O(wave), .PIN_D_CONNECT_O(pin), .PIN_D_N_CONNECT_O(pin_n),
    .PWM_D_ENABLE_O(), .WAVE_MODE_O(wmode), .SHADOW_MODE_A_O(), .SHADOW_MODE_B_O(),
    .FAULT_EVENT_I(f_ev), .FAULT_VECTOR_ACK_I(f_ack), .FAULT_IRQ_O(irq), .FAULT_CFG_O(fcfg));
  power_stage_model stage_u (.wave_i(wave), .connect_i(pin), .gate_o(gate));

  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bus cycles: one-cycle strobes, read data in the following cycle
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 0;
    #1;
  endtask
  task automatic rd_reg(logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    rd <= 1; addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk("rdata", rdata, exp);
  endtask
  // One counter event, then the stage gate is compared
  task automatic ev(logic m, logic z, logic d, logic e);
    @(posedge clk);
    evt <= '{m, z, d};
    @(posedge clk);
    evt <= '0;
    #1 chk("gate", 8'(gate), 8'(e));
  endtask
  // Ticks in a 64-cycle window, a whole number of periods for every divisor up to eight
  task automatic cnt(logic [7:0] d, int et, int ed);
    wr_reg(ADDR_CLK_DT_CTRL, d);
    repeat (2) @(posedge clk);
    nt = 0; nd = 0;
    repeat (64)
    begin
      @(posedge clk);
      #1 nt += t_tick; nd += d_tick;
    end
    chk("timer ticks", 8'(nt), 8'(et));
    if (ed >= 0) chk("deadtime ticks", 8'(nd), 8'(ed));
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done;
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1;
    rd_reg(ADDR_FAULT_WAVE_CTRL, 8'h00);
    rd_reg(ADDR_CHAN_D_OUT_CTRL, 8'h00);
    rd_reg(ADDR_CLK_DT_CTRL, 8'h00);
    rd_reg(8'h30, 8'h00);
    cnt(8'h00, 0, -1);
    for (int i = 0; i < 4; i++) cnt(8'(i * 17 + 1), 64 >> i, 64 >> i);
    cnt(8'h4f, 0, -1);
    rd_reg(ADDR_CLK_DT_CTRL, 8'h0f);
    // Prescaler reset with divide by four: first tick comes four ticks after restart
    wr_reg(ADDR_CLK_DT_CTRL, 8'h43);
    repeat (4) @(posedge clk);
    #1 chk("tick after reset", 8'(t_tick), 8'h00);
    @(posedge clk);
    #1 chk("tick after reset", 8'(t_tick), 8'h01);
    @(posedge clk) async_m <= 1;
    cnt(8'h01, 32, 32);
    @(posedge clk) async_m <= 0;
    wr_reg(ADDR_CLK_DT_CTRL, 8'h80);
    @(posedge clk);
    #1 chk("dt pair", 8'(dt_o), 8'h01);
    // Forced toggle, clear, set, then a match toggle
    wr_reg(ADDR_CHAN_D_OUT_CTRL, 8'h06);
    // Pin connect is registered from the stored mode, one cycle behind the waveform
    @(posedge clk);
    #1 chk("gate", 8'(gate), 8'h01);
    wr_reg(ADDR_CHAN_D_OUT_CTRL, 8'h0a);
    chk("gate", 8'(gate), 8'h00);
    wr_reg(ADDR_CHAN_D_OUT_CTRL, 8'h0e);
    chk("gate", 8'(gate), 8'h01);
    wr_reg(ADDR_CHAN_D_OUT_CTRL, 8'h04);
    ev(1, 0, 0, 0);
    wr_reg(ADDR_CHAN_D_OUT_CTRL, 8'ha6);
    rd_reg(ADDR_CHAN_D_OUT_CTRL, 8'ha4);
    // Every wave mode with modes 01 and 11; bit 1 of m is the inverted sense
    for (int m = 1; m < 4; m += 2)
      for (int w = 0; w < 4; w++)
      begin
        wr_reg(ADDR_FAULT_WAVE_CTRL, 8'(w));
        wr_reg(ADDR_CHAN_D_OUT_CTRL, 8'(m * 4 + 1));
        chk("wave mode", 8'(wmode), 8'(w));
        @(posedge clk);
        #1 chk("pin_n", 8'(pin_n), 8'(m == 1));
        ev(1, 0, 1, w[0] ? !m[1] : m[1]);
        ev(1, 0, 0, m[1]);
        ev(0, 1, 0, w[0] ? m[1] : !m[1]);
      end
    wr_reg(ADDR_CHAN_D_OUT_CTRL, 8'h0b);
    chk("gate", 8'(gate), 8'h01);
    // Fault flag cleared by a written one, then by the vector
    wr_reg(ADDR_FAULT_WAVE_CTRL, 8'h80);
    @(posedge clk) f_ev <= 1;
    @(posedge clk) f_ev <= 0;
    @(posedge clk);
    #1 chk("irq", 8'(irq), 8'h01);
    wr_reg(ADDR_FAULT_WAVE_CTRL, 8'h84);
    rd_reg(ADDR_FAULT_WAVE_CTRL, 8'h80);
    @(posedge clk) f_ev <= 1;
    @(posedge clk) f_ev <= 0;
    @(posedge clk) f_ack <= 1;
    @(posedge clk) f_ack <= 0;
    rd_reg(ADDR_FAULT_WAVE_CTRL, 8'h80);
    // Fault configuration bits are plain storage; a zero in the flag bit keeps it clear
    wr_reg(ADDR_FAULT_WAVE_CTRL, 8'h78);
    chk("fault cfg", 8'(fcfg), 8'h0f);
    rd_reg(ADDR_FAULT_WAVE_CTRL, 8'h78);
    test_done;
  end
endmodule
